// [include/svd_consts.svh]
// constants for the supply voltage detector control block
// assumes one 40 MHz bus clock and Avalon-MM word addressing by byte
`ifndef SVD_CONSTS_SVH
`define SVD_CONSTS_SVH
`define CTRL_OFFSET       16'hff12
`define IRQ_STAT_OFFSET   16'hff14
`define IRQ_MASK_OFFSET   16'hff18
`define ONTIME_OFFSET     16'hff1c
`define THR_LSB           0
`define THR_MSB           3
`define ON_BIT            4
`define RESULT_BIT        5
`define CTRL_RESET        8'h00
`define THR_MIN_VALID     4'h3
`define CLK_MHZ           40
`define MIN_ON_US         500
`define MIN_ON_CYCLES     (`MIN_ON_US * `CLK_MHZ)
`define EV_DONE_BIT       0
`define EV_LOW_BIT        1
`define EV_EARLY_BIT      2
`endif

// [include/svd_pkg.sv]
// types for the supply voltage detector control block
// assumes svd_consts.svh is included by the user of the types
package svd_pkg;
  typedef enum logic [1:0] {st_off, st_settling, st_ready} det_state_t;
endpackage : svd_pkg

// [rtl/supply_voltage_detect_ctrl.sv]
// control and result latch for the on-chip supply voltage detector
// assumes an Avalon-MM master on clk and an analog comparator output that is asynchronous
`timescale 1ns/100ps
`include "svd_consts.svh"
module supply_voltage_detect_ctrl
  import svd_pkg::*;
#(
  parameter int unsigned MIN_ON_CYCLES = `MIN_ON_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic      [1:0]  response,
  input  wire logic        supply_low_async,
  output logic             detector_enable,
  output logic      [3:0]  threshold_select,
  output logic             threshold_valid,
  output logic             irq
);

  // register state
  logic [3:0]  thr_r;
  logic        on_r;
  logic        result_r;
  logic [2:0]  stat_r;
  logic [2:0]  mask_r;
  logic        sync1_r;
  logic        sync2_r;
  logic [31:0] on_cnt_r;
  det_state_t  state_r;
  det_state_t  state_nxt;
  logic        ack_r;
  logic        threshold_valid_r;

  // decode of the bus request; one wait cycle, answer on the second edge
  wire         req        = read | write;
  wire         take       = req & ack_r;
  wire         hit_ctrl   = (address == `CTRL_OFFSET);
  wire         hit_stat   = (address == `IRQ_STAT_OFFSET);
  wire         hit_mask   = (address == `IRQ_MASK_OFFSET);
  wire         hit_ontime = (address == `ONTIME_OFFSET);
  wire         hit_any    = hit_ctrl | hit_stat | hit_mask | hit_ontime;
  wire         wr_ctrl    = take & write & hit_ctrl & byteenable[0];
  wire         wr_mask    = take & write & hit_mask & byteenable[0];
  wire         rd_stat    = take & read & hit_stat;
  wire         on_wdata   = writedata[`ON_BIT];
  wire         turn_off   = wr_ctrl & on_r & ~on_wdata;
  wire         settled    = (state_r == st_ready);

  // status events: done capture, low verdict, clear before settling time
  wire [2:0] ev;
  assign ev[`EV_DONE_BIT]  = turn_off;
  assign ev[`EV_LOW_BIT]   = turn_off & sync2_r;
  assign ev[`EV_EARLY_BIT] = turn_off & ~settled;

  // read mux; bits above each field read zero
  wire [7:0] ctrl_view = {2'b00, result_r, on_r, thr_r};
  wire [31:0] rd_mux =
    hit_ctrl   ? {24'h000000, ctrl_view} :
    hit_stat   ? {29'h00000000, stat_r} :
    hit_mask   ? {29'h00000000, mask_r} :
    hit_ontime ? on_cnt_r : 32'h00000000;

  // a code below 3 has no threshold assigned
  function automatic logic code_valid(input logic [3:0] code);
    code_valid = (code >= `THR_MIN_VALID);
  endfunction : code_valid

  // next values; the first request cycle is the single wait state
  wire         first_cycle     = req & ~ack_r;
  wire         ack_nxt         = first_cycle;
  wire         waitrequest_nxt = ~first_cycle;                        // low exactly on the taking edge
  wire [31:0]  readdata_nxt    = first_cycle ? rd_mux : readdata;
  wire [1:0]   response_nxt    = first_cycle ? (hit_any ? 2'h0 : 2'h3) : response; // unmapped: decode error
  wire [3:0]   thr_nxt         = wr_ctrl ? writedata[`THR_MSB:`THR_LSB] : thr_r;
  wire         on_nxt          = wr_ctrl ? on_wdata : on_r;
  wire         result_nxt      = turn_off ? sync2_r : result_r;
  wire [2:0]   stat_nxt        = (rd_stat ? 3'h0 : stat_r) | ev;      // event beats the read clear
  wire [2:0]   mask_nxt        = wr_mask ? writedata[2:0] : mask_r;
  wire         irq_nxt         = |(stat_nxt & mask_r);
  wire         thr_valid_nxt   = code_valid(thr_nxt);

  // settling tracker: counts on time so software can see it is safe
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_off:      if (on_r) state_nxt = st_settling;
      st_settling: if (!on_r) state_nxt = st_off;
                   else if (on_cnt_r >= MIN_ON_CYCLES - 1) state_nxt = st_ready;
      st_ready:    if (!on_r) state_nxt = st_off;
      default:     state_nxt = st_off;
    endcase
  end

  // comparator synchroniser, second stage alone feeds logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= supply_low_async;
      sync2_r <= sync1_r;
    end
  end

  // threshold select field
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      thr_r <= 4'h0;
    end
    else
    begin
      thr_r <= thr_nxt;
    end
  end

  // detector on bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_r <= 1'b0;
    end
    else
    begin
      on_r <= on_nxt;
    end
  end

  // result latch; bus writes never reach it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_r <= 1'b0;
    end
    else
    begin
      result_r <= result_nxt;
    end
  end

  // on-time counter saturates; software polls it instead of a timer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_cnt_r <= 32'h00000000;
      state_r  <= st_off;
    end
    else
    begin
      state_r <= state_nxt;
      if (!on_r)
        on_cnt_r <= 32'h00000000;
      else if (on_cnt_r != 32'hffffffff)
        on_cnt_r <= on_cnt_r + 32'h00000001;
    end
  end

  // sticky status, read clears, a same-cycle event wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_r <= 3'h0;
    end
    else
    begin
      stat_r <= stat_nxt;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_r <= 3'h0;
    end
    else
    begin
      mask_r <= mask_nxt;
    end
  end

  // answer phase marker
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= ack_nxt;
    end
  end

  // waitrequest idles high so a stray level is never taken
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
    end
    else
    begin
      waitrequest <= waitrequest_nxt;
    end
  end

  // read data stand until the next request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readdata <= 32'h00000000;
    end
    else
    begin
      readdata <= readdata_nxt;
    end
  end

  // response code of the last request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      response <= 2'h0;
    end
    else
    begin
      response <= response_nxt;
    end
  end

  // analog power follows the on bit without a cycle of lag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      detector_enable <= 1'b0;
    end
    else
    begin
      detector_enable <= on_nxt;
    end
  end

  // threshold code to the comparator
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      threshold_select <= 4'h0;
    end
    else
    begin
      threshold_select <= thr_nxt;
    end
  end

  // low for an unassigned code; the comparator output is meaningless then
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      threshold_valid_r <= 1'b0;
    end
    else
    begin
      threshold_valid_r <= thr_valid_nxt;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_nxt;
    end
  end

  assign threshold_valid = threshold_valid_r;

endmodule : supply_voltage_detect_ctrl

// [bench/supply_voltage_detect_ctrl_props.sv]
// port assertions for the detector control block
// assumes one clock domain; bound into the design
`timescale 1ns/100ps
`include "svd_consts.svh"
module supply_voltage_detect_ctrl_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [15:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        detector_enable,
  input wire logic [3:0]  threshold_select,
  input wire logic        threshold_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // bus steps: request seen, control write taken, control read answered
  sequence req_seen;
    (read || write) && waitrequest;
  endsequence
  sequence ctrl_wr;
    write && !waitrequest && address == `CTRL_OFFSET && byteenable[0];
  endsequence
  sequence ctrl_rd;
    read && !waitrequest && address == `CTRL_OFFSET;
  endsequence
  one_wait_a:
    assert property (req_seen |=> !waitrequest) else $error("request not answered");
  wait_pulse_a:
    assert property (!waitrequest |=> waitrequest) else $error("answer longer than one cycle");
  thr_valid_a:
    assert property (threshold_valid == (threshold_select >= `THR_MIN_VALID)) else $error("valid flag wrong");
  on_follow_a:
    assert property (ctrl_wr |=> ##1 detector_enable == $past(writedata[`ON_BIT], 2)) else $error("enable wrong");
  thr_follow_a:
    assert property (ctrl_wr |=> ##1 threshold_select == $past(writedata[3:0], 2)) else $error("code wrong");
  rsv_zero_a:
    assert property (ctrl_rd |-> readdata[31:6] == 26'h0) else $error("upper bits set");
  mapped_ok_a:
    assert property (ctrl_rd |-> response == 2'b00) else $error("control read refused");
  unmapped_a:
    assert property (read && !waitrequest && address == 16'h0010 |-> response == 2'b11 && readdata == 32'h0)
      else $error("unmapped read accepted");
endmodule : supply_voltage_detect_ctrl_props
bind supply_voltage_detect_ctrl supply_voltage_detect_ctrl_props u_props (.*);

// [bench/comparator_model.sv]
// behavioural supply comparator beside the block
// assumes supply and threshold in the same code units
`timescale 1ns/100ps
module comparator_model (
  input  wire logic       clk,
  input  wire logic       detector_enable,
  input  wire logic [3:0] threshold_select,
  input  wire logic [3:0] supply_level,
  output logic            supply_low_async
);
  logic junk_r = 1'b0;
  // unpowered output is garbage, so toggle it
  always @(posedge clk) junk_r <= ~junk_r;
  assign supply_low_async = detector_enable ? (supply_level < threshold_select) : junk_r;
endmodule : comparator_model

// [bench/supply_voltage_detect_ctrl_bench.sv]
// self-checking bench for the detector control block
// assumes the comparator model and a 40 MHz clock
`timescale 1ns/100ps
`include "svd_consts.svh"
module supply_voltage_detect_ctrl_bench;
  logic        clk = 0, reset_n = 0, read = 0, write = 0, sl, de, tv, irq, wreq, low, prev = 0;
  logic [15:0] address = 0;
  logic [31:0] writedata = 0, readdata, exp_q[$];
  logic [3:0]  thr, lvl = 0, ts;
  logic [1:0]  resp;
  int          n_mismatch = 0, comparisons = 0, wt;
  supply_voltage_detect_ctrl #(.MIN_ON_CYCLES(20)) DUT (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(wreq), .response(resp), .supply_low_async(sl), .detector_enable(de),
    .threshold_select(ts), .threshold_valid(tv), .irq(irq));
  comparator_model u_cmp (.clk(clk), .detector_enable(de), .threshold_select(ts), .supply_level(lvl),
    .supply_low_async(sl));
  initial forever #12.5 clk = ~clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // hold the request until waitrequest is seen low
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    write <= 0;
    read <= 0;
    @(posedge clk);
  endtask : bus
  task rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask : rd
  // read answers pop the oldest note
  always @(posedge clk)
    if (read && wreq === 1'b0)
      check(readdata, exp_q.pop_front());
  task complete_run;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // watchdog well past the under two hundred cycles needed
  initial
  begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  // main sequence; one short on time to flag an early capture
  initial
  begin
    void'($urandom(71));
    repeat (6) @(posedge clk);
    reset_n <= 1;
    rd(`CTRL_OFFSET, 32'h0);
    rd(16'h0010, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      thr = 4'($urandom % 13 + 3);
      lvl <= 4'($urandom);
      wt = (i == 1) ? 6 : 25;
      bus(1, `IRQ_MASK_OFFSET, (i == 3) ? 32'h0 : 32'h7);
      bus(1, `CTRL_OFFSET, {26'h0, 2'b11, thr});
      rd(`CTRL_OFFSET, {26'h0, prev, 1'b1, thr});
      repeat (wt) @(posedge clk);
      bus(1, `CTRL_OFFSET, {28'h0, thr});
      check({31'h0, de}, 32'h0);
      low = lvl < thr;
      prev = low;
      rd(`CTRL_OFFSET, {26'h0, low, 1'b0, thr});
      check({31'h0, irq}, {31'h0, i < 3});
      rd(`IRQ_STAT_OFFSET, {29'h0, wt < 20, low, 1'b1});
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0);
    end
    complete_run;
  end
endmodule : supply_voltage_detect_ctrl_bench
